// ---- design/ppm_consts.vh ----
// constants for the port pin function multiplexer
//
// Overview of operation
// - Reset loads all ones into the eight bits of the upper port output latch.
// - Reset loads all ones into the special-function port latch and makes its pins quasi-bidirectional.
// - Reset makes the upper port pins quasi-bidirectional until software picks another configuration.
// - Software picks the output configuration of every pin on its own, and the pin follows it while neither the external bus nor programming mode owns the pin.
// - With a sixteen-bit external bus the upper port alternates between the high data byte and address lines 12 to 19.
// - With an eight-bit external bus only the software-chosen number of upper address lines appear on the upper port.
// - During program memory verify the programmer drives the low address byte onto the upper port and the device takes it there.
// - During program memory programming and verify the programmer drives the high address bits onto the special-function port and the device takes them there.
// - Special-function port bit zero feeds serial port zero receive and bit one carries serial port zero transmit.
// - Special-function port bit two feeds external interrupt zero.
// - Special-function port bit four is timer zero count input or timer zero overflow output.
// - The timer zero pin is sampled as reset is released and the level is kept as a default setting.
// - Lower port bit six is timer two count input or its clock output.
// - Lower port bit seven is the timer two reload, capture or direction input.
// - Lower port bit four is the serial port one receive input.
`ifndef PPM_CONSTS_VH
`define PPM_CONSTS_VH

// ----------------------------------------------------------------
// output configurations, two bits per pin
// ----------------------------------------------------------------
`define PPM_CFG_QUASI     2'h0
`define PPM_CFG_PUSH      2'h1
`define PPM_CFG_OPEN      2'h2
`define PPM_CFG_INPUT     2'h3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PPM_LATCH_RST     8'hff
`define PPM_CFG_RST       16'h0000
`define PPM_LO_LATCH_RST  3'h7
`define PPM_LO_CFG_RST    6'h00

// ----------------------------------------------------------------
// pin positions
// ----------------------------------------------------------------
`define PPM_NPINS         19
`define PPM_SF_BASE       8
`define PPM_LO_BASE       16
`define PPM_SF_RX0        0
`define PPM_SF_TX0        1
`define PPM_SF_EXT_INTERRUPT_ZERO_IN       2
`define PPM_SF_T0         4
`define PPM_LO_RX1        0
`define PPM_LO_T2         1
`define PPM_LO_TIMER_TWO_RELOAD_CAPTURE_CTL       2
`define PPM_ADDR_FIRST    12
`define PPM_ADDR_CNT_W    4

`endif

// ---- design/ppm_pin_cell.v ----
// one port pin: input synchroniser and configured output driver
`timescale 1ns/1ps
`default_nettype none
`include "ppm_consts.vh"

module ppm_pin_cell (
    input  wire       clk,
    input  wire       rst,
    input  wire       pin_in,
    input  wire [1:0] cfg,
    input  wire       latch_val,
    input  wire       alt_sel,
    input  wire       alt_val,
    input  wire       bus_own,
    input  wire       bus_drive,
    input  wire       bus_val,
    output reg        pin_out_q,
    output reg        pin_oe_n_q,
    output reg        in_sync_q
);

    // ----------------------------------------------------------------
    // two-flop input synchroniser
    // ----------------------------------------------------------------
    reg meta_q;

    always @(posedge clk) begin
        meta_q    <= pin_in;
        in_sync_q <= meta_q;
    end

    // ----------------------------------------------------------------
    // driver selection
    // ----------------------------------------------------------------
    reg val_d;
    reg drv_d;

    always @* begin
        val_d = alt_sel ? alt_val : latch_val;
        drv_d = 1'b0;
        if (bus_own) begin
            val_d = bus_val;
            drv_d = bus_drive;
        end else begin
            case (cfg)
                `PPM_CFG_QUASI: drv_d = ~val_d;
                `PPM_CFG_OPEN:  drv_d = ~val_d;
                `PPM_CFG_PUSH:  drv_d = 1'b1;
                `PPM_CFG_INPUT: drv_d = 1'b0;
                default:        drv_d = 1'b0;
            endcase
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            pin_out_q  <= 1'b1;
            pin_oe_n_q <= 1'b1;
        end else begin
            pin_out_q  <= val_d;
            pin_oe_n_q <= ~drv_d;
        end
    end

endmodule
`default_nettype wire

// ---- design/ppm_port_mux.v ----
// pin function multiplexer for the upper, special-function and lower ports
`timescale 1ns/1ps
`default_nettype none
`include "ppm_consts.vh"

module ppm_port_mux (
    input  wire        clk,
    input  wire        rst,
    // upper port pins
    input  wire [7:0]  upper_port_pins_in,
    output wire [7:0]  upper_port_pins_out,
    output wire [7:0]  upper_port_pins_oe_n,
    // special-function port pins
    input  wire [7:0]  special_function_port_pins_in,
    output wire [7:0]  special_function_port_pins_out,
    output wire [7:0]  special_function_port_pins_oe_n,
    // lower port pins 4, 6, 7
    input  wire [2:0]  lower_port_pins_in,
    output wire [2:0]  lower_port_pins_out,
    output wire [2:0]  lower_port_pins_oe_n,
    // latch and configuration writes from the core
    input  wire        upper_latch_wr,
    input  wire [7:0]  upper_latch_wdata,
    input  wire        upper_cfg_wr,
    input  wire [15:0] upper_cfg_wdata,
    input  wire        sf_latch_wr,
    input  wire [7:0]  sf_latch_wdata,
    input  wire        sf_cfg_wr,
    input  wire [15:0] sf_cfg_wdata,
    input  wire        lower_latch_wr,
    input  wire [2:0]  lower_latch_wdata,
    input  wire        lower_cfg_wr,
    input  wire [5:0]  lower_cfg_wdata,
    // external bus
    input  wire        ebus_en,
    input  wire        ebus_wide,
    input  wire        ebus_addr_phase,
    input  wire        ebus_write,
    input  wire [7:0]  ebus_addr_hi,
    input  wire [7:0]  ebus_data_hi_out,
    input  wire [3:0]  ebus_addr_line_count,
    // program memory programming and verify
    input  wire        prog_mode,
    // alternate function sources
    input  wire        serial0_transmit_out,
    input  wire        serial0_tx_en,
    input  wire        timer_zero_ovf_out,
    input  wire        timer_zero_out_en,
    input  wire        timer_two_clkout,
    input  wire        timer_two_clkout_en,
    // towards the core
    output wire [7:0]  upper_port_read,
    output wire [7:0]  sf_port_read,
    output wire [7:0]  ebus_data_hi_in,
    output wire [7:0]  prog_addr_lo,
    output wire [7:0]  prog_addr_hi,
    output wire        serial0_receive_in,
    output wire        ext_interrupt_zero_in,
    output wire        timer_zero_io_count,
    output reg         timer_zero_strap_q,
    output wire        timer_two_count_clkout,
    output wire        timer_two_reload_capture_ctl,
    output wire        serial1_receive_in
);

    // ----------------------------------------------------------------
    // port latches and configuration
    // ----------------------------------------------------------------
    reg [7:0]  upper_latch_q;
    reg [15:0] upper_cfg_q;
    reg [7:0]  sf_latch_q;
    reg [15:0] sf_cfg_q;
    reg [2:0]  lower_latch_q;
    reg [5:0]  lower_cfg_q;
    reg        rst_q;

    always @(posedge clk) begin
        if (rst) begin
            upper_latch_q <= `PPM_LATCH_RST;
            upper_cfg_q   <= `PPM_CFG_RST;
            sf_latch_q    <= `PPM_LATCH_RST;
            sf_cfg_q      <= `PPM_CFG_RST;
            lower_latch_q <= `PPM_LO_LATCH_RST;
            lower_cfg_q   <= `PPM_LO_CFG_RST;
        end else begin
            if (upper_latch_wr) begin
                upper_latch_q <= upper_latch_wdata;
            end
            if (upper_cfg_wr) begin
                upper_cfg_q <= upper_cfg_wdata;
            end
            if (sf_latch_wr) begin
                sf_latch_q <= sf_latch_wdata;
            end
            if (sf_cfg_wr) begin
                sf_cfg_q <= sf_cfg_wdata;
            end
            if (lower_latch_wr) begin
                lower_latch_q <= lower_latch_wdata;
            end
            if (lower_cfg_wr) begin
                lower_cfg_q <= lower_cfg_wdata;
            end
        end
    end

    // ----------------------------------------------------------------
    // timer zero strap caught on reset release
    // ----------------------------------------------------------------
    wire [`PPM_NPINS-1:0] in_sync;

    always @(posedge clk) begin
        rst_q <= rst;
        if (rst) begin
            timer_zero_strap_q <= 1'b0;
        end else if (rst_q) begin
            timer_zero_strap_q <= in_sync[`PPM_SF_BASE+`PPM_SF_T0];
        end
    end

    // ----------------------------------------------------------------
    // pin cells
    // ----------------------------------------------------------------
    wire [`PPM_NPINS-1:0] pin_in;
    wire [`PPM_NPINS-1:0] pin_out;
    wire [`PPM_NPINS-1:0] pin_oe_n;
    wire [`PPM_NPINS-1:0] c_latch;
    wire [`PPM_NPINS-1:0] c_alt_sel;
    wire [`PPM_NPINS-1:0] c_alt_val;
    wire [`PPM_NPINS-1:0] c_bus_own;
    wire [`PPM_NPINS-1:0] c_bus_drive;
    wire [`PPM_NPINS-1:0] c_bus_val;
    wire [2*`PPM_NPINS-1:0] c_cfg;

    assign pin_in  = {lower_port_pins_in, special_function_port_pins_in, upper_port_pins_in};
    assign c_latch = {lower_latch_q, sf_latch_q, upper_latch_q};
    assign c_cfg   = {lower_cfg_q, sf_cfg_q, upper_cfg_q};

    genvar gi;
    generate
        for (gi = 0; gi < `PPM_NPINS; gi = gi + 1) begin : g_pin
            if (gi < `PPM_SF_BASE) begin : g_upper
                localparam integer IDX = gi;
                wire addr_line;
                assign addr_line = ebus_wide | ({28'h0, ebus_addr_line_count} > IDX);
                assign c_bus_own[gi]   = prog_mode | (ebus_en & addr_line);
                assign c_bus_drive[gi] = ~prog_mode
                                         & (~ebus_wide | ebus_addr_phase | ebus_write);
                assign c_bus_val[gi]   = (ebus_wide & ~ebus_addr_phase)
                                         ? ebus_data_hi_out[gi]
                                         : ebus_addr_hi[gi];
                assign c_alt_sel[gi]   = 1'b0;
                assign c_alt_val[gi]   = 1'b0;
            end else if (gi < `PPM_LO_BASE) begin : g_sf
                assign c_bus_own[gi]   = prog_mode;
                assign c_bus_drive[gi] = 1'b0;
                assign c_bus_val[gi]   = 1'b1;
                if (gi == `PPM_SF_BASE + `PPM_SF_TX0) begin : g_tx0
                    assign c_alt_sel[gi] = serial0_tx_en;
                    assign c_alt_val[gi] = serial0_transmit_out;
                end else if (gi == `PPM_SF_BASE + `PPM_SF_T0) begin : g_t0
                    assign c_alt_sel[gi] = timer_zero_out_en;
                    assign c_alt_val[gi] = timer_zero_ovf_out;
                end else begin : g_plain
                    assign c_alt_sel[gi] = 1'b0;
                    assign c_alt_val[gi] = 1'b0;
                end
            end else begin : g_lower
                assign c_bus_own[gi]   = 1'b0;
                assign c_bus_drive[gi] = 1'b0;
                assign c_bus_val[gi]   = 1'b1;
                if (gi == `PPM_LO_BASE + `PPM_LO_T2) begin : g_t2
                    assign c_alt_sel[gi] = timer_two_clkout_en;
                    assign c_alt_val[gi] = timer_two_clkout;
                end else begin : g_plain
                    assign c_alt_sel[gi] = 1'b0;
                    assign c_alt_val[gi] = 1'b0;
                end
            end

            ppm_pin_cell u_cell (
                .clk        (clk),
                .rst        (rst),
                .pin_in     (pin_in[gi]),
                .cfg        (c_cfg[2*gi +: 2]),
                .latch_val  (c_latch[gi]),
                .alt_sel    (c_alt_sel[gi]),
                .alt_val    (c_alt_val[gi]),
                .bus_own    (c_bus_own[gi]),
                .bus_drive  (c_bus_drive[gi]),
                .bus_val    (c_bus_val[gi]),
                .pin_out_q  (pin_out[gi]),
                .pin_oe_n_q (pin_oe_n[gi]),
                .in_sync_q  (in_sync[gi])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // pin and core side outputs
    // ----------------------------------------------------------------
    assign upper_port_pins_out             = pin_out[7:0];
    assign upper_port_pins_oe_n            = pin_oe_n[7:0];
    assign special_function_port_pins_out  = pin_out[15:8];
    assign special_function_port_pins_oe_n = pin_oe_n[15:8];
    assign lower_port_pins_out             = pin_out[18:16];
    assign lower_port_pins_oe_n            = pin_oe_n[18:16];

    assign upper_port_read  = in_sync[7:0];
    assign sf_port_read     = in_sync[15:8];
    assign ebus_data_hi_in  = in_sync[7:0];
    assign prog_addr_lo     = in_sync[7:0];
    assign prog_addr_hi     = in_sync[15:8];

    assign serial0_receive_in           = in_sync[`PPM_SF_BASE+`PPM_SF_RX0];
    assign ext_interrupt_zero_in        = in_sync[`PPM_SF_BASE+`PPM_SF_EXT_INTERRUPT_ZERO_IN];
    assign timer_zero_io_count          = in_sync[`PPM_SF_BASE+`PPM_SF_T0];
    assign serial1_receive_in           = in_sync[`PPM_LO_BASE+`PPM_LO_RX1];
    assign timer_two_count_clkout       = in_sync[`PPM_LO_BASE+`PPM_LO_T2];
    assign timer_two_reload_capture_ctl = in_sync[`PPM_LO_BASE+`PPM_LO_TIMER_TWO_RELOAD_CAPTURE_CTL];

endmodule
`default_nettype wire

// ---- tb/ppm_far_side.sv ----
// board side of one port: programmer, peripherals and pull-ups
`timescale 1ns/1ps
`default_nettype none
module ppm_far_side #(
    parameter int W = 8
) (
    input  wire logic [W-1:0] dev_out,
    input  wire logic [W-1:0] dev_oe_n,
    input  wire logic [W-1:0] drv_val,
    input  wire logic [W-1:0] drv_en,
    output var  logic [W-1:0] pin
);
    // clash gives unknown, released pin floats to the pull-up
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (!dev_oe_n[i] && drv_en[i]) pin[i] = 1'bx;
            else if (!dev_oe_n[i]) pin[i] = dev_out[i];
            else if (drv_en[i]) pin[i] = drv_val[i];
            else pin[i] = 1'b1;
        end
    end
endmodule
`default_nettype wire

// ---- tb/ppm_port_mux_props.sv ----
// assertions on the ports of the pin function multiplexer
`timescale 1ns/1ps
`default_nettype none
module ppm_port_mux_props (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic [7:0] upper_port_pins_in,
    input wire logic [7:0] upper_port_pins_out,
    input wire logic [7:0] upper_port_pins_oe_n,
    input wire logic [7:0] special_function_port_pins_in,
    input wire logic [7:0] special_function_port_pins_out,
    input wire logic [7:0] special_function_port_pins_oe_n,
    input wire logic [2:0] lower_port_pins_in,
    input wire logic       ebus_en,
    input wire logic       ebus_wide,
    input wire logic       ebus_addr_phase,
    input wire logic       ebus_write,
    input wire logic [7:0] ebus_addr_hi,
    input wire logic [7:0] ebus_data_hi_out,
    input wire logic [3:0] ebus_addr_line_count,
    input wire logic       prog_mode,
    input wire logic [7:0] prog_addr_lo,
    input wire logic [7:0] prog_addr_hi,
    input wire logic       serial0_receive_in,
    input wire logic       ext_interrupt_zero_in,
    input wire logic       timer_zero_io_count,
    input wire logic       timer_zero_strap_q,
    input wire logic       timer_two_count_clkout,
    input wire logic       timer_two_reload_capture_ctl,
    input wire logic       serial1_receive_in
);
    logic [7:0] cnt_mask;
    assign cnt_mask = (ebus_addr_line_count > 4'h7) ? 8'hff
                    : ((8'h01 << ebus_addr_line_count) - 8'h01);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_rst;
        disable iff (1'b0) rst |=> {upper_port_pins_out, upper_port_pins_oe_n,
            special_function_port_pins_out, special_function_port_pins_oe_n} == 32'hffffffff;
    endproperty
    a_rst: assert property (p_rst) else $error("port state wrong in reset");
    property p_wide;
        ebus_en && ebus_wide && !prog_mode |=> upper_port_pins_out == ($past(ebus_addr_phase)
            ? $past(ebus_addr_hi) : $past(ebus_data_hi_out)) && upper_port_pins_oe_n
            == (($past(ebus_addr_phase) || $past(ebus_write)) ? 8'h00 : 8'hff);
    endproperty
    a_wide: assert property (p_wide) else $error("wide bus pins wrong");
    property p_narrow;
        ebus_en && !ebus_wide && !prog_mode |=> (((upper_port_pins_out ^ $past(ebus_addr_hi))
            | upper_port_pins_oe_n) & $past(cnt_mask)) == 8'h00;
    endproperty
    a_narrow: assert property (p_narrow) else $error("narrow bus lines wrong");
    property p_prog_rel;
        prog_mode |=> {upper_port_pins_oe_n, special_function_port_pins_oe_n} == 16'hffff;
    endproperty
    a_prog_rel: assert property (p_prog_rel) else $error("pins driven in prog");
    property p_prog_addr;
        prog_mode |-> {prog_addr_hi, prog_addr_lo}
            == {$past(special_function_port_pins_in, 2), $past(upper_port_pins_in, 2)};
    endproperty
    a_prog_addr: assert property (p_prog_addr) else $error("prog address wrong");
    property p_sf_reads;
        {serial0_receive_in, ext_interrupt_zero_in, timer_zero_io_count}
            == {$past(special_function_port_pins_in[0], 2),
            $past(special_function_port_pins_in[2], 2), $past(special_function_port_pins_in[4], 2)};
    endproperty
    a_sf_reads: assert property (p_sf_reads) else $error("sf input wrong");
    property p_lo_reads;
        {serial1_receive_in, timer_two_count_clkout, timer_two_reload_capture_ctl}
            == {$past(lower_port_pins_in[0], 2), $past(lower_port_pins_in[1], 2),
            $past(lower_port_pins_in[2], 2)};
    endproperty
    a_lo_reads: assert property (p_lo_reads) else $error("lower input wrong");
    property p_strap;
        $past(rst) && !rst |=> timer_zero_strap_q == $past(special_function_port_pins_in[4], 3);
    endproperty
    a_strap: assert property (p_strap) else $error("strap capture wrong");
endmodule
bind ppm_port_mux ppm_port_mux_props u_ppm_port_mux_props (.*);
`default_nettype wire

// ---- tb/ppm_port_mux_tb.sv ----
// self-checking bench for the port pin function multiplexer
`timescale 1ns/1ps
`default_nettype none
module ppm_port_mux_tb;
    logic        clk, rst, prog_mode, ebus_en, ebus_wide, ebus_addr_phase, ebus_write;
    logic        upper_latch_wr, upper_cfg_wr, sf_latch_wr, sf_cfg_wr, lower_latch_wr;
    logic        lower_cfg_wr, serial0_transmit_out, serial0_tx_en, timer_zero_ovf_out;
    logic        timer_zero_out_en, timer_two_clkout, timer_two_clkout_en;
    logic [7:0]  upper_latch_wdata, sf_latch_wdata, ebus_addr_hi, ebus_data_hi_out;
    logic [7:0]  up_drv_val, up_drv_en, sf_drv_val, sf_drv_en;
    logic [15:0] upper_cfg_wdata, sf_cfg_wdata;
    logic [5:0]  lower_cfg_wdata;
    logic [3:0]  ebus_addr_line_count;
    logic [2:0]  lower_latch_wdata, lo_drv_val, lo_drv_en;
    wire  [7:0]  upper_port_pins_in, upper_port_pins_out, upper_port_pins_oe_n, upper_port_read;
    wire  [7:0]  special_function_port_pins_in, special_function_port_pins_out, sf_port_read;
    wire  [7:0]  special_function_port_pins_oe_n, ebus_data_hi_in, prog_addr_lo, prog_addr_hi;
    wire  [2:0]  lower_port_pins_in, lower_port_pins_out, lower_port_pins_oe_n;
    wire         serial0_receive_in, ext_interrupt_zero_in, timer_zero_io_count;
    wire         timer_zero_strap_q, timer_two_count_clkout, timer_two_reload_capture_ctl;
    wire         serial1_receive_in;
    int          err_total = 0;
    int          checks = 0;

    ppm_port_mux u_ppm_port_mux (.*);
    ppm_far_side #(.W(8)) u_far_up (.dev_out(upper_port_pins_out),
        .dev_oe_n(upper_port_pins_oe_n), .drv_val(up_drv_val), .drv_en(up_drv_en),
        .pin(upper_port_pins_in));
    ppm_far_side #(.W(8)) u_far_sf (.dev_out(special_function_port_pins_out),
        .dev_oe_n(special_function_port_pins_oe_n), .drv_val(sf_drv_val), .drv_en(sf_drv_en),
        .pin(special_function_port_pins_in));
    ppm_far_side #(.W(3)) u_far_lo (.dev_out(lower_port_pins_out),
        .dev_oe_n(lower_port_pins_oe_n), .drv_val(lo_drv_val), .drv_en(lo_drv_en),
        .pin(lower_port_pins_in));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic finish_test;
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        #1;
        chk({upper_port_pins_out, upper_port_pins_oe_n}, 16'hffff);
        chk({special_function_port_pins_out, special_function_port_pins_oe_n}, 16'hffff);
        cyc(2);
        chk({15'h0, timer_zero_strap_q}, 16'h0001);
        @(posedge clk);
        sf_drv_en <= 8'h10;
        cyc(4);
        chk({15'h0, timer_zero_strap_q}, 16'h0001);
        @(posedge clk);
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        cyc(2);
        chk({15'h0, timer_zero_strap_q}, 16'h0000);
        @(posedge clk);
        sf_drv_en <= 8'h00;
    endtask

    task automatic t_latch;
        @(posedge clk);
        upper_latch_wr <= 1'b1;
        upper_cfg_wr <= 1'b1;
        upper_cfg_wdata <= 16'he4e4;
        @(posedge clk);
        upper_latch_wdata <= 8'hff;
        upper_cfg_wr <= 1'b0;
        @(posedge clk);
        upper_latch_wr <= 1'b0;
        #1;
        chk({upper_port_pins_out, upper_port_pins_oe_n}, 16'h0088);
        cyc(1);
        chk({upper_port_pins_out, upper_port_pins_oe_n}, 16'hffdd);
        @(posedge clk);
        up_drv_en <= 8'hdd;
        cyc(3);
        chk({8'h0, upper_port_read}, 16'h0022);
        @(posedge clk);
        up_drv_en <= 8'h00;
        upper_cfg_wr <= 1'b1;
        upper_cfg_wdata <= 16'h0000;
        @(posedge clk);
        upper_cfg_wr <= 1'b0;
    endtask

    task automatic t_wide;
        @(posedge clk);
        ebus_en <= 1'b1;
        ebus_wide <= 1'b1;
        ebus_addr_phase <= 1'b1;
        ebus_addr_hi <= 8'ha5;
        ebus_data_hi_out <= 8'h3c;
        cyc(2);
        chk({upper_port_pins_out, upper_port_pins_oe_n}, 16'ha500);
        @(posedge clk);
        ebus_addr_phase <= 1'b0;
        ebus_write <= 1'b1;
        cyc(2);
        chk({upper_port_pins_out, upper_port_pins_oe_n}, 16'h3c00);
        @(posedge clk);
        ebus_write <= 1'b0;
        @(posedge clk);
        up_drv_en <= 8'hff;
        up_drv_val <= 8'h96;
        cyc(3);
        chk({upper_port_pins_oe_n, ebus_data_hi_in}, 16'hff96);
        @(posedge clk);
        up_drv_en <= 8'h00;
        ebus_en <= 1'b0;
    endtask

    task automatic t_narrow;
        logic [7:0] m;
        for (int n = 0; n < 9; n++) begin
            @(posedge clk);
            ebus_en <= 1'b1;
            ebus_wide <= 1'b0;
            ebus_addr_hi <= 8'h5a;
            ebus_addr_line_count <= 4'(n);
            cyc(2);
            m = (n == 8) ? 8'hff : 8'((9'h1 << n) - 9'h1);
            chk({upper_port_pins_out, upper_port_pins_oe_n}, {(8'h5a & m) | ~m, ~m});
        end
        @(posedge clk);
        ebus_en <= 1'b0;
    endtask

    task automatic t_prog;
        @(posedge clk);
        prog_mode <= 1'b1;
        upper_latch_wr <= 1'b1;
        upper_latch_wdata <= 8'h00;
        sf_latch_wr <= 1'b1;
        @(posedge clk);
        upper_latch_wr <= 1'b0;
        sf_latch_wr <= 1'b0;
        @(posedge clk);
        up_drv_en <= 8'hff;
        up_drv_val <= 8'h3e;
        sf_drv_en <= 8'hff;
        sf_drv_val <= 8'hc1;
        cyc(3);
        chk({prog_addr_hi, prog_addr_lo}, 16'hc13e);
        chk({upper_port_pins_oe_n, special_function_port_pins_oe_n}, 16'hffff);
        @(posedge clk);
        prog_mode <= 1'b0;
        {up_drv_en, sf_drv_en} <= 16'h0000;
        {upper_latch_wr, sf_latch_wr, lower_latch_wr} <= 3'h7;
        {upper_latch_wdata, sf_latch_wdata, lower_latch_wdata} <= 19'h7ffff;
        @(posedge clk);
        {upper_latch_wr, sf_latch_wr, lower_latch_wr} <= 3'h0;
    endtask

    task automatic t_alt;
        @(posedge clk);
        {sf_drv_en, sf_drv_val, lo_drv_en, lo_drv_val} <= {8'h15, 8'h04, 3'h7, 3'h6};
        cyc(4);
        chk({sf_port_read, 5'h0, serial0_receive_in, ext_interrupt_zero_in,
            timer_zero_io_count}, 16'hee02);
        chk({serial1_receive_in, timer_two_count_clkout,
            timer_two_reload_capture_ctl}, 16'h0003);
        @(posedge clk);
        {sf_drv_en, lo_drv_en} <= 11'h000;
        {sf_cfg_wr, lower_cfg_wr, sf_cfg_wdata, lower_cfg_wdata} <= {2'h3, 16'h0104, 6'h04};
        {serial0_tx_en, timer_zero_out_en, timer_two_clkout_en} <= 3'h7;
        @(posedge clk);
        {sf_cfg_wr, lower_cfg_wr} <= 2'h0;
        cyc(2);
        chk({special_function_port_pins_out[1], special_function_port_pins_out[4],
            lower_port_pins_out[1], special_function_port_pins_oe_n[1],
            special_function_port_pins_oe_n[4], lower_port_pins_oe_n[1]}, 16'h0000);
        @(posedge clk);
        {serial0_transmit_out, timer_zero_ovf_out, timer_two_clkout} <= 3'h7;
        cyc(2);
        chk({special_function_port_pins_out[1], special_function_port_pins_out[4],
            lower_port_pins_out[1], special_function_port_pins_oe_n[1],
            special_function_port_pins_oe_n[4], lower_port_pins_oe_n[1]}, 16'h0038);
    endtask

    initial begin
        {prog_mode, ebus_en, ebus_wide, ebus_addr_phase, ebus_write, upper_latch_wr,
            upper_cfg_wr, sf_latch_wr, sf_cfg_wr, lower_latch_wr, lower_cfg_wr} = '0;
        {serial0_transmit_out, serial0_tx_en, timer_zero_ovf_out, timer_zero_out_en,
            timer_two_clkout, timer_two_clkout_en, lower_cfg_wdata, ebus_addr_line_count} = '0;
        {upper_latch_wdata, sf_latch_wdata, ebus_addr_hi, ebus_data_hi_out, up_drv_val} = '0;
        {up_drv_en, sf_drv_val, sf_drv_en, upper_cfg_wdata, sf_cfg_wdata} = '0;
        {lower_latch_wdata, lo_drv_val, lo_drv_en} = '0;
        rst = 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_latch();
        t_wide();
        t_narrow();
        t_prog();
        t_alt();
        finish_test();
    end

    initial begin
        #20000;
        err_total++;
        finish_test();
    end
endmodule
`default_nettype wire
